// ==== rtl/lcfm_pkg.sv ====
// lcfm_pkg: constants and types for the led channel fault manager
// assumes one 250 MHz core clock and a 32-bit word register port with 4-bit addresses
package lcfm_pkg;
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned NCH            = 6;
  // deglitch and pwm timing, figures as printed
  localparam int unsigned OPEN_DG_NS     = 4000;
  localparam int unsigned SHORT_DG_NS    = 100;
  localparam int unsigned OPEN_DG_CYC    = (OPEN_DG_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SHORT_DG_CYC   = (SHORT_DG_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PWM_FREQ_HZ    = 1000;
  localparam int unsigned PWM_PERIOD_CYC = CLK_MHZ * 1000000 / PWM_FREQ_HZ;
  // delay ramp charge per cycle
  localparam logic [16:0] RAMP_STEP      = 17'h00001;
  // cycles after reset release before straps are caught
  localparam logic [1:0]  STRAP_LAST     = 2'h2;
  // register offsets
  localparam logic [3:0]  OFS_DELAY      = 4'h0;
  localparam logic [3:0]  OFS_DUTY       = 4'h4;
  localparam logic [3:0]  OFS_STATUS     = 4'h8;
  localparam logic [3:0]  OFS_EVENT      = 4'hc;
  // field widths, all fields at bit 0
  localparam int unsigned DELAY_W        = 16;
  localparam int unsigned DUTY_W         = 8;
  localparam logic [15:0] DELAY_RST      = 16'h0100;
  localparam logic [7:0]  DUTY_RST       = 8'h80;
  // fault kinds
  localparam int unsigned IX_OPEN        = 0;
  localparam int unsigned IX_OVC         = 1;
  localparam int unsigned IX_OT          = 2;
  localparam int unsigned NFLT           = 3;

  typedef enum logic [1:0] {
    Q_IDLE = 2'b00,
    Q_DGL  = 2'b01,
    Q_RAMP = 2'b11,
    Q_HOLD = 2'b10
  } lcfm_qstate_e;

  typedef struct packed {
    logic [2:0]     qual;
    logic           line_hi;
    logic           drive;
    logic           uv_en;
    logic [NCH-1:0] dis;
    logic [NCH-1:0] en;
  } lcfm_status_s;
endpackage : lcfm_pkg

// ==== rtl/lcfm_qual.sv ====
// lcfm_qual: deglitch then delay ramp for one fault flag
// assumes flag_i is already synchronous to clk_i
`timescale 1ns/1ps
module lcfm_qual #(
  parameter int unsigned DG_CYC = lcfm_pkg::SHORT_DG_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        clr_i,
  input  wire logic        flag_i,
  input  wire logic [15:0] thr_i,
  output logic             qual_o
);
  localparam int unsigned   DW      = $clog2(DG_CYC + 1);
  localparam logic [DW-1:0] DG_LAST = DW'(DG_CYC - 1);

  lcfm_pkg::lcfm_qstate_e st_r;
  logic [DW-1:0]          dg_r;
  logic [16:0]            ramp_r;

  generate
    if (DG_CYC < 1) begin : g_bad
      $error("lcfm_qual: DG_CYC must be at least 1");
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r   <= lcfm_pkg::Q_IDLE;
      dg_r   <= '0;
      ramp_r <= '0;
    end else if (clr_i || !flag_i) begin
      // abort: next occurrence starts from zero
      st_r   <= lcfm_pkg::Q_IDLE;
      dg_r   <= '0;
      ramp_r <= '0;
    end else begin
      case (st_r)
        lcfm_pkg::Q_IDLE: begin
          st_r <= lcfm_pkg::Q_DGL;
        end
        lcfm_pkg::Q_DGL: begin
          if (dg_r == DG_LAST) begin
            st_r <= lcfm_pkg::Q_RAMP;
          end else begin
            dg_r <= dg_r + DW'(1);
          end
        end
        lcfm_pkg::Q_RAMP: begin
          if (ramp_r + lcfm_pkg::RAMP_STEP >= {1'b0, thr_i}) begin
            st_r <= lcfm_pkg::Q_HOLD;
          end else begin
            ramp_r <= ramp_r + lcfm_pkg::RAMP_STEP;
          end
        end
        default: begin
          st_r <= lcfm_pkg::Q_HOLD;
        end
      endcase
    end
  end

  assign qual_o = (st_r == lcfm_pkg::Q_HOLD);
endmodule : lcfm_qual

// ==== rtl/lcfm_top.sv ====
// lcfm_top: fault supervision and channel enables of a six channel sink
// assumes async comparator pins, a wired open-drain fault line with pull-up
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
// Contract
// - fault line is open-drain: released when idle, pulled low on fault
// - sensed line high enables outputs, sensed low shuts them all off; the code keeps a visible open channel on
// - any device pulling the shared line low turns off all others; here a visible open channel stays on
// - open-led flag needs about 4 us deglitch before the delay
// - overcurrent or overtemperature needs about 100 ns deglitch
// - after deglitch a ramp runs to its threshold, then line asserts
// - power removal clears every fault report; normal after power returns
// - open-led reporting only while undervoltage enable is above threshold; tail mode can report an open held from a pwm fall before the drop
// - open-led reporting stays on until input drops 100 mV below
// - open channel stays on, others off, line asserts after delay
// - outside stop and tail the circuit powers down and clears report
// - on re-entry a lasting fault reasserts after delay, else all on
// - overcurrent turns all off, reports after delay, releases on clear
// - in stop mode a qualified fault reports after the total delay
// - in tail mode reporting depends on delay and dimming pwm
// - in tail mode faults are sampled only at pwm falling edge
// - a fault shorter than the programmed delay is never reported; tail mode holds one seen at pwm fall a period and can report it
// - channels grounded at power-up are disabled and never diagnosed
// - dimming pwm runs at fixed 1 kHz with programmable duty
module lcfm_top #(
  parameter int unsigned PWM_PERIOD_CYC = lcfm_pkg::PWM_PERIOD_CYC
) (
  input  wire logic                     CORE_CLK_I,
  input  wire logic                     RESETN_I,
  input  wire logic [3:0]               REG_ADDR_I,
  input  wire logic [31:0]              REG_WDATA_I,
  input  wire logic                     REG_WR_I,
  input  wire logic                     REG_RD_I,
  output logic      [31:0]              REG_RDATA_O,
  input  wire logic                     STOP_I,
  input  wire logic                     TAIL_I,
  input  wire logic [lcfm_pkg::NCH-1:0] OPEN_I,
  input  wire logic                     OVERCUR_I,
  input  wire logic                     OVERTEMP_I,
  input  wire logic                     UV_ABOVE_I,
  input  wire logic                     UV_BELOW_HYST_I,
  input  wire logic [lcfm_pkg::NCH-1:0] OUT_GND_I,
  input  wire logic                     FAULT_LINE_I,
  output logic                          FAULT_LINE_O,
  output logic                          FAULT_LINE_OE_O,
  output logic      [lcfm_pkg::NCH-1:0] CH_EN_O,
  output logic                          PWM_O
);
  localparam int unsigned NCH = lcfm_pkg::NCH;
  localparam int unsigned SW  = 2 * NCH + 7;
  localparam int unsigned PW  = $clog2(PWM_PERIOD_CYC);

  generate
    if (PWM_PERIOD_CYC < 2) begin : g_bad
      $error("lcfm_top: PWM_PERIOD_CYC must be at least 2");
    end
  endgenerate

  // pin synchroniser
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  logic          stop_s;
  logic          tail_s;
  logic [NCH-1:0] open_s;
  logic          ovc_s;
  logic          ot_s;
  logic          uv_above_s;
  logic          uv_below_s;
  logic [NCH-1:0] gnd_s;
  logic          line_s;

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {FAULT_LINE_I, OUT_GND_I, UV_BELOW_HYST_I, UV_ABOVE_I,
                  OVERTEMP_I, OVERCUR_I, OPEN_I, TAIL_I, STOP_I};
      sync2_r <= sync1_r;
    end
  end

  assign {line_s, gnd_s, uv_below_s, uv_above_s,
          ot_s, ovc_s, open_s, tail_s, stop_s} = sync2_r;

  // power-up strap capture of grounded channels
  logic [1:0]     settle_r;
  logic           ready_r;
  logic [NCH-1:0] chan_dis_r;

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      settle_r   <= '0;
      ready_r    <= 1'b0;
      chan_dis_r <= '0;
    end else if (!ready_r) begin
      if (settle_r == lcfm_pkg::STRAP_LAST) begin
        ready_r    <= 1'b1;
        chan_dis_r <= gnd_s;
      end else begin
        settle_r <= settle_r + 2'h1;
      end
    end
  end

  // register file
  logic [15:0] dly_thr_r;
  logic [7:0]  duty_r;
  logic [2:0]  ev_r;
  logic [2:0]  ev_clr;
  logic [31:0] rdata_r;
  logic [31:0] rd_val;
  lcfm_pkg::lcfm_status_s status;

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      dly_thr_r <= lcfm_pkg::DELAY_RST;
      duty_r    <= lcfm_pkg::DUTY_RST;
    end else if (REG_WR_I) begin
      if (REG_ADDR_I == lcfm_pkg::OFS_DELAY) begin
        dly_thr_r <= REG_WDATA_I[lcfm_pkg::DELAY_W-1:0];
      end else if (REG_ADDR_I == lcfm_pkg::OFS_DUTY) begin
        duty_r <= REG_WDATA_I[lcfm_pkg::DUTY_W-1:0];
      end
    end
  end

  assign ev_clr = (REG_WR_I && REG_ADDR_I == lcfm_pkg::OFS_EVENT) ?
                  REG_WDATA_I[2:0] : 3'h0;

  always_comb begin
    rd_val = '0;
    if (REG_ADDR_I == lcfm_pkg::OFS_DELAY) begin
      rd_val = {16'h0000, dly_thr_r};
    end else if (REG_ADDR_I == lcfm_pkg::OFS_DUTY) begin
      rd_val = {24'h000000, duty_r};
    end else if (REG_ADDR_I == lcfm_pkg::OFS_STATUS) begin
      rd_val = 32'(status);
    end else if (REG_ADDR_I == lcfm_pkg::OFS_EVENT) begin
      rd_val = {29'h00000000, ev_r};
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= REG_RD_I ? rd_val : 32'h00000000;
    end
  end

  assign REG_RDATA_O = rdata_r;

  // dimming pwm, fixed period
  logic [PW-1:0]   pwm_cnt_r;
  logic [PW+7:0]   on_lim;
  logic            pwm_on_r;
  logic            pwm_fall;

  assign on_lim = ((PW+8)'(PWM_PERIOD_CYC) * (PW+8)'(duty_r)) >> 8;

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pwm_cnt_r <= '0;
      pwm_on_r  <= 1'b0;
    end else begin
      if (pwm_cnt_r == PW'(PWM_PERIOD_CYC - 1)) begin
        pwm_cnt_r <= '0;
      end else begin
        pwm_cnt_r <= pwm_cnt_r + PW'(1);
      end
      pwm_on_r <= {8'h00, pwm_cnt_r} < on_lim;
    end
  end

  assign PWM_O = pwm_on_r;

  logic pwm_prev_r;

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pwm_prev_r <= 1'b0;
    end else begin
      pwm_prev_r <= pwm_on_r;
    end
  end

  assign pwm_fall = pwm_prev_r && !pwm_on_r;

  // open-led reporting enable with hysteresis
  logic uv_en_r;

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      uv_en_r <= 1'b0;
    end else if (uv_above_s) begin
      uv_en_r <= 1'b1;
    end else if (uv_below_s) begin
      uv_en_r <= 1'b0;
    end
  end

  // detection and tail sampling
  logic           active;
  logic           tail_only;
  logic [NCH-1:0] open_vis;
  logic [2:0]     det;
  logic [2:0]     smp_r;
  logic [2:0]     qin;
  logic [2:0]     qual;

  assign active    = ready_r && (stop_s || tail_s);
  assign tail_only = tail_s && !stop_s;
  assign open_vis  = open_s & ~chan_dis_r & {NCH{uv_en_r}};
  assign det       = {ot_s, ovc_s, |open_vis};

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      smp_r <= '0;
    end else if (!active) begin
      smp_r <= '0;
    end else if (pwm_fall) begin
      smp_r <= det;
    end
  end

  // stop uses live flags, tail the sampled ones
  assign qin = active ? (tail_only ? smp_r : det) : 3'h0;

  generate
    for (genvar g = 0; g < lcfm_pkg::NFLT; g++) begin : g_flt
      localparam int unsigned DG = (g == lcfm_pkg::IX_OPEN) ?
                                   lcfm_pkg::OPEN_DG_CYC : lcfm_pkg::SHORT_DG_CYC;
      logic [31:0] run_r;

      lcfm_qual #(
        .DG_CYC (DG)
      ) u_qual (
        .clk_i  (CORE_CLK_I),
        .rstn_i (RESETN_I),
        .clr_i  (!active),
        .flag_i (qin[g]),
        .thr_i  (dly_thr_r),
        .qual_o (qual[g])
      );

      // helper: cycles the qualifier input has stood high
      always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
          run_r <= '0;
        end else if (!qin[g]) begin
          run_r <= '0;
        end else if (run_r != 32'hffffffff) begin
          run_r <= run_r + 32'h00000001;
        end
      end

      chk_qual_delay: assert property (
        @(posedge CORE_CLK_I) disable iff (!RESETN_I)
        $rose(qual[g]) |-> run_r >= DG + 32'(dly_thr_r)
      ) else $error("fault reported before deglitch and delay elapsed");
    end
  endgenerate

  // line drive and event log
  logic       drive_r;
  logic [2:0] qual_prev_r;

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      drive_r <= 1'b0;
    end else begin
      drive_r <= |qual;
    end
  end

  assign FAULT_LINE_O    = 1'b0;
  assign FAULT_LINE_OE_O = drive_r;

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      qual_prev_r <= '0;
      ev_r        <= '0;
    end else begin
      qual_prev_r <= qual;
      // new reports win over a clear in the same cycle
      ev_r <= (ev_r & ~ev_clr) | (qual & ~qual_prev_r);
    end
  end

  // channel enables
  logic [NCH-1:0] ch_en_nxt;
  logic [NCH-1:0] ch_en_r;
  logic [NCH-1:0] dim;

  assign dim = {NCH{!tail_only || pwm_on_r}};

  always_comb begin
    ch_en_nxt = '0;
    if (!active || ovc_s || ot_s) begin
      ch_en_nxt = '0;
    end else if (open_vis != '0) begin
      ch_en_nxt = open_vis & dim;
    end else if (line_s) begin
      ch_en_nxt = ~chan_dis_r & dim;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ch_en_r <= '0;
    end else begin
      ch_en_r <= ch_en_nxt;
    end
  end

  assign CH_EN_O = ch_en_r;

  assign status.qual    = qual;
  assign status.line_hi = line_s;
  assign status.drive   = drive_r;
  assign status.uv_en   = uv_en_r;
  assign status.dis     = chan_dis_r;
  assign status.en      = ch_en_r;

  chk_line_drive: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    (|qual) |=> FAULT_LINE_OE_O && !FAULT_LINE_O
  ) else $error("qualified fault did not pull the line");

  chk_line_low_off: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    (!line_s && open_vis == '0) |=> CH_EN_O == '0
  ) else $error("outputs on while shared line reads low");

  chk_uv_gate: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    (!uv_en_r && !uv_above_s && !tail_only) |=> !qual[lcfm_pkg::IX_OPEN]
  ) else $error("open fault qualified while reporting disabled");

  chk_uv_hyst: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    (uv_en_r && !uv_below_s) |=> uv_en_r
  ) else $error("open reporting dropped above hysteresis level");

  chk_open_keep: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    (active && !tail_only && !ovc_s && !ot_s && open_vis != '0)
      |=> CH_EN_O == $past(open_vis)
  ) else $error("open channel not kept alone on");

  chk_idle_clear: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    !active |=> (CH_EN_O == '0) ##1 !FAULT_LINE_OE_O
  ) else $error("idle device still reports or drives");

  chk_ovc_off: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    ovc_s |=> CH_EN_O == '0
  ) else $error("channels on during overcurrent");

  chk_tail_sample: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    (active && !pwm_fall) |=> $stable(smp_r)
  ) else $error("tail sample changed off the pwm falling edge");

  chk_strap_mask: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    (CH_EN_O & chan_dis_r) == '0
  ) else $error("grounded channel enabled");
endmodule : lcfm_top

// ==== testbench/lcfm_peer.sv ====
// lcfm_peer: behavioural peer driver on the shared fault line
// assumes the bench resolves the wired line with a pull-up
`timescale 1ns/1ps
module lcfm_peer (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic line_i,
  input  wire logic fault_i,
  output logic      pull_oe_o,
  output logic      off_o
);
  // pull low only while own fault stands
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) pull_oe_o <= 1'b0;
    else pull_oe_o <= fault_i;
  end
  // own outputs shut while the line reads low
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) off_o <= 1'b1;
    else off_o <= ~line_i;
  end
endmodule : lcfm_peer

// ==== testbench/led_channel_fault_manager_test.sv ====
// led_channel_fault_manager_test: self-checking bench for lcfm_top
// assumes a short pwm period and one peer on the wired fault line
`timescale 1ns/1ps
module led_channel_fault_manager_test;
  localparam int unsigned PER = 64;
  logic        clk, rst_n, wr, rd, stop, tail, ovc, ot, uva, uvb, peer_f;
  logic        oe, fo, pwm, line, peer_oe, peer_off;
  logic [3:0]  addr;
  logic [31:0] wd, rdat, d;
  logic [5:0]  opn, gnd, en;
  int          bad_count, comparisons, n, h, l;
  // pull-up wins unless someone drives low
  assign line = ~((oe & ~fo) | peer_oe);
  lcfm_top #(.PWM_PERIOD_CYC(PER)) u_lcfm_top (
    .CORE_CLK_I(clk), .RESETN_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wd),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat), .STOP_I(stop), .TAIL_I(tail),
    .OPEN_I(opn), .OVERCUR_I(ovc), .OVERTEMP_I(ot), .UV_ABOVE_I(uva),
    .UV_BELOW_HYST_I(uvb), .OUT_GND_I(gnd), .FAULT_LINE_I(line), .FAULT_LINE_O(fo),
    .FAULT_LINE_OE_O(oe), .CH_EN_O(en), .PWM_O(pwm));
  lcfm_peer u_lcfm_peer (.clk_i(clk), .rstn_i(rst_n), .line_i(line), .fault_i(peer_f),
    .pull_oe_o(peer_oe), .off_o(peer_off));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : tick
  task automatic wait_oe(input logic v, input int lim, output int c);
    c = 0;
    while (oe !== v && c < lim) begin
      tick(1);
      c++;
    end
  endtask : wait_oe
  task automatic wait_pwm(input logic v, output int c);
    c = 0;
    while (pwm !== v && c < 200) begin
      tick(1);
      c++;
    end
  endtask : wait_pwm
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk); wr <= 1'b1; addr <= a; wd <= v;
    @(posedge clk); wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk); rd <= 1'b1; addr <= a;
    @(posedge clk); rd <= 1'b0;
    #1 v = rdat;
  endtask : reg_rd
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task automatic t_regs;
    check("oe_rst", oe, 1'b0);
    check("fo", fo, 1'b0);
    reg_rd(4'h0, d);
    check("delay_rst", d, 32'h0000_0100);
    reg_rd(4'h4, d);
    check("duty_rst", d, 32'h0000_0080);
    reg_rd(4'h2, d);
    check("unmapped", d, 32'h0);
    reg_wr(4'h0, 32'h0000_0004);
    reg_rd(4'h0, d);
    check("delay_wr", d, 32'h0000_0004);
    tick(4);
    check("en_norm", en, 6'h1f);
    check("line_hi", line, 1'b1);
    reg_rd(4'h8, d);
    check("status", d, 32'h0000_481f);
  endtask : t_regs
  task automatic t_hard;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      ovc <= (k == 0);
      ot  <= (k == 1);
      tick(8);
      check("en_off", en, 6'h0);
      wait_oe(1'b1, 60, n);
      check("hard_lat", (n >= 20 && n <= 30), 1'b1);
      tick(2);
      check("peer_off", peer_off, 1'b1);
      reg_rd(4'hc, d);
      check("event", d, (k == 0) ? 32'h0000_0002 : 32'h0000_0004);
      reg_wr(4'hc, 32'h0000_0007);
      @(posedge clk);
      ovc <= 1'b0;
      ot  <= 1'b0;
      wait_oe(1'b0, 10, n);
      check("hard_rel", oe, 1'b0);
      tick(4);
      check("en_back", en, 6'h1f);
    end
  endtask : t_hard
  task automatic t_short;
    repeat (2) begin
      @(posedge clk);
      ovc <= 1'b1;
      tick(20);
      check("short_hi", oe, 1'b0);
      @(posedge clk);
      ovc <= 1'b0;
      tick(10);
    end
    tick(40);
    check("short", oe, 1'b0);
  endtask : t_short
  task automatic t_open;
    @(posedge clk); opn <= 6'h24;
    tick(1100);
    check("uv_off", oe, 1'b0);
    @(posedge clk);
    uva <= 1'b1;
    uvb <= 1'b0;
    wait_oe(1'b1, 1100, n);
    check("open_lat", (n >= 1000 && n <= 1015), 1'b1);
    tick(2);
    check("open_en", en, 6'h04);
    @(posedge clk);
    uva <= 1'b0;
    tick(20);
    check("hyst", oe, 1'b1);
    @(posedge clk);
    uvb <= 1'b1;
    wait_oe(1'b0, 20, n);
    check("uv_dis", oe, 1'b0);
    tick(4);
    check("uv_en", en, 6'h1f);
    @(posedge clk); opn <= 6'h0;
  endtask : t_open
  task automatic t_idle;
    @(posedge clk); ovc <= 1'b1;
    wait_oe(1'b1, 60, n);
    @(posedge clk); stop <= 1'b0;
    wait_oe(1'b0, 10, n);
    check("idle_oe", oe, 1'b0);
    check("idle_en", en, 6'h0);
    @(posedge clk);
    stop <= 1'b1;
    wait_oe(1'b1, 60, n);
    check("re_lat", (n >= 20 && n <= 34), 1'b1);
    check("re_en", en, 6'h0);
    @(posedge clk);
    ovc <= 1'b0;
    wait_oe(1'b0, 10, n);
    tick(4);
    check("re_clr", en, 6'h1f);
  endtask : t_idle
  task automatic t_peer;
    @(posedge clk);
    peer_f <= 1'b1;
    tick(6);
    check("peer_en", en, 6'h0);
    check("peer_oe", oe, 1'b0);
    @(posedge clk);
    peer_f <= 1'b0;
    tick(6);
    check("peer_rel", en, 6'h1f);
  endtask : t_peer
  task automatic t_tail;
    @(posedge clk); stop <= 1'b0; tail <= 1'b1;
    tick(4);
    wait_pwm(1'b0, n); wait_pwm(1'b1, n);
    wait_pwm(1'b0, h); wait_pwm(1'b1, l);
    check("pwm_per", h + l, PER);
    check("pwm_hi", h, PER / 2);
    @(posedge clk);
    ovc <= 1'b1;
    wait_oe(1'b1, 200, n);
    check("tail_rep", (oe === 1'b1 && n >= PER / 2 + 25 && n <= PER + 40), 1'b1);
    @(posedge clk); ovc <= 1'b0;
    wait_oe(1'b0, 200, n);
    @(posedge clk); stop <= 1'b1; tail <= 1'b0;
  endtask : t_tail
  task automatic t_power;
    @(posedge clk); ovc <= 1'b1;
    wait_oe(1'b1, 800, n);
    @(posedge clk); rst_n <= 1'b0;
    tick(1);
    check("pwr_oe", oe, 1'b0);
    @(posedge clk);
    ovc   <= 1'b0;
    rst_n <= 1'b1;
    tick(8);
    check("pwr_en", en, 6'h1f);
    check("pwr_oe2", oe, 1'b0);
    reg_rd(4'hc, d);
    check("pwr_ev", d, 32'h0);
  endtask : t_power

  initial begin
    rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 4'h0; wd = 32'h0;
    stop = 1'b1; tail = 1'b0; ovc = 1'b0; ot = 1'b0; opn = 6'h0;
    uva = 1'b0; uvb = 1'b1; gnd = 6'h20; peer_f = 1'b0;
    bad_count = 0; comparisons = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs(); t_hard(); t_short(); t_open();
    t_idle(); t_peer(); t_tail(); t_power();
    close_out();
  end
  // hang guard, well past the expected few thousand cycles
  initial begin
    #(20000 * 4);
    bad_count++;
    close_out();
  end
endmodule : led_channel_fault_manager_test
